// [core/romx_pkg.sv]
// Shared constants of the relay output function multiplexer.
// Assumes one 200 MHz clock; all offsets are APB byte addresses.
package romx_pkg;

  // Geometry
  localparam int NUM_RELAY = 12;
  localparam int NUM_CFG = 7;
  localparam int SEL_W = 5;
  localparam int NODE_W = 8;
  localparam int KVA_W = 16;

  // Relay bit positions (output number minus one)
  localparam int RLY_GEN_CLOSE = 0;
  localparam int RLY_GEN_OPEN = 1;
  localparam int RLY_FUEL = 4;
  localparam int RLY_STARTER = 6;
  localparam int RLY_HORN = 8;
  localparam int CFG_RELAY_POS [NUM_CFG] = '{2, 3, 5, 7, 9, 10, 11};

  // Function selections
  localparam logic [SEL_W-1:0] FN_NONE = 5'h01;
  localparam logic [SEL_W-1:0] FN_BUS_TRIP = 5'h02;
  localparam logic [SEL_W-1:0] FN_PREGLOW = 5'h03;
  localparam logic [SEL_W-1:0] FN_IDLE_RATED = 5'h04;
  localparam logic [SEL_W-1:0] FN_AIR_SHUTOFF = 5'h05;
  localparam logic [SEL_W-1:0] FN_IGNITION = 5'h06;
  localparam logic [SEL_W-1:0] FN_SPEED_RAISE = 5'h07;
  localparam logic [SEL_W-1:0] FN_SPEED_LOWER = 5'h08;
  localparam logic [SEL_W-1:0] FN_VOLT_RAISE = 5'h09;
  localparam logic [SEL_W-1:0] FN_VOLT_LOWER = 5'h0A;
  localparam logic [SEL_W-1:0] FN_ENGINE_RUN = 5'h0B;
  localparam logic [SEL_W-1:0] FN_ENERGY_PULSE = 5'h0C;
  localparam logic [SEL_W-1:0] FN_AI3_ALARM = 5'h0D;
  localparam logic [SEL_W-1:0] FN_AI4_ALARM = 5'h0E;
  localparam logic [SEL_W-1:0] FN_GEN_ONLY = 5'h0F;
  localparam logic [SEL_W-1:0] FN_APPARENT_POWER_THRESHOLD_FLAG = 5'h10;
  localparam logic [SEL_W-1:0] FN_AI3_PRE = 5'h11;
  localparam logic [SEL_W-1:0] FN_AI4_PRE = 5'h12;
  localparam logic [SEL_W-1:0] FN_VISUAL = 5'h13;
  localparam logic [SEL_W-1:0] FN_SOFT_SD = 5'h14;
  localparam logic [SEL_W-1:0] FN_HARD_SD = 5'h15;
  localparam logic [SEL_W-1:0] FN_NODE_MISMATCH = 5'h16;
  localparam logic [SEL_W-1:0] FN_SELF_TEST = 5'h17;
  localparam logic [SEL_W-1:0] FN_MIN = FN_NONE;
  localparam logic [SEL_W-1:0] FN_MAX = FN_SELF_TEST;

  // Reset values, index 0 is output 3
  localparam logic [NUM_CFG-1:0][SEL_W-1:0] SEL_RST =
    {FN_HARD_SD, FN_SOFT_SD, FN_VISUAL, FN_IDLE_RATED, FN_PREGLOW, FN_BUS_TRIP, FN_NONE};
  localparam logic [NUM_CFG-1:0] POL_RST = 7'h00;
  localparam logic [NODE_W-1:0] NODE_EXP_RST = 8'h01;
  localparam logic [KVA_W-1:0] KVA_THR_RST = 16'hFFFF;

  // Register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_POL = 12'h004;
  localparam logic [11:0] OFS_NODE_EXP = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_KVA_THR = 12'h010;
  localparam logic [11:0] OFS_SEL0 = 12'h020;
  localparam logic [11:0] OFS_SEL_LAST = 12'h038;

  // Field positions
  localparam int CTRL_LOCK_BIT = 0;
  localparam int STAT_LATCH_LSB = 12;

  // Timing
  localparam longint CLK_KHZ = 200000;
  localparam longint AIR_SHUTOFF_MS = 5000;
  localparam longint ENERGY_PULSE_MS = 100;
  localparam longint AIR_SHUTOFF_CYC = AIR_SHUTOFF_MS * CLK_KHZ;
  localparam longint ENERGY_PULSE_CYC = ENERGY_PULSE_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_DONE = 3'b100
  } romx_bus_state_t;

endpackage : romx_pkg

// [core/romx_cfg_if.sv]
// Carrier between the bus front end and the configuration store.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
`default_nettype none
interface romx_cfg_if;
  import romx_pkg::*;
  logic wrEn;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic wrOk;
  logic [NUM_CFG-1:0][SEL_W-1:0] sel;
  logic [NUM_CFG-1:0] pol;
  logic [NODE_W-1:0] nodeExp;
  logic [KVA_W-1:0] kvaThr;
  logic ioLock;

  modport front (output wrEn, wrAddr, wrData, ioLock, input wrOk, sel, pol, nodeExp, kvaThr);
  modport store (input wrEn, wrAddr, wrData, ioLock, output wrOk, sel, pol, nodeExp, kvaThr);
endinterface : romx_cfg_if
`default_nettype wire

// [core/romx_pulse_timer.sv]
// One-shot timer: active for LEN cycles from the trigger, retriggerable.
// Assumes trig is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module romx_pulse_timer #(
  parameter int CNT_W = 32,
  parameter logic [CNT_W-1:0] LEN = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Trigger and result
  input wire logic trig,
  output logic active
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic act;
  } romx_tmr_t;

  romx_tmr_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (trig) begin
      s_d.cnt = LEN - 1'b1;
      s_d.act = 1'b1;
    end else if (s_q.act) begin
      if (s_q.cnt == '0) begin
        s_d.act = 1'b0;
      end else begin
        s_d.cnt = s_q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign active = s_q.act;
endmodule : romx_pulse_timer
`default_nettype wire

// [core/romx_cfg_store.sv]
// Configuration store: selectors, polarity, node number, kVA threshold.
// Assumes writes arrive as single-cycle strobes from the bus front end.
`timescale 1ns/1ps
`default_nettype none
module romx_cfg_store
  import romx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Carrier
  romx_cfg_if.store cfg
);
  typedef struct packed {
    logic [NUM_CFG-1:0][SEL_W-1:0] sel;
    logic [NUM_CFG-1:0] pol;
    logic [NODE_W-1:0] nodeExp;
    logic [KVA_W-1:0] kvaThr;
  } romx_store_t;

  romx_store_t s_q, s_d;
  logic [SEL_W-1:0] newSel;
  logic selHit;
  logic [2:0] selIdx;
  logic addrOk;

  always_comb begin
    s_d = s_q;
    newSel = cfg.wrData[SEL_W-1:0];
    selHit = (cfg.wrAddr >= OFS_SEL0) && (cfg.wrAddr <= OFS_SEL_LAST) && (cfg.wrAddr[1:0] == 2'b00);
    selIdx = 3'((cfg.wrAddr - OFS_SEL0) >> 2);
    // Selection outside the enumeration is refused
    addrOk = (cfg.wrAddr == OFS_POL) || (cfg.wrAddr == OFS_NODE_EXP) ||
             (cfg.wrAddr == OFS_KVA_THR) || (selHit && newSel >= FN_MIN && newSel <= FN_MAX);
    cfg.wrOk = cfg.ioLock && addrOk;
    if (cfg.wrEn && cfg.wrOk) begin
      if (selHit) begin
        s_d.sel[selIdx] = newSel;
      end
      if (cfg.wrAddr == OFS_POL) begin
        s_d.pol = cfg.wrData[NUM_CFG-1:0];
      end
      if (cfg.wrAddr == OFS_NODE_EXP) begin
        s_d.nodeExp = cfg.wrData[NODE_W-1:0];
      end
      if (cfg.wrAddr == OFS_KVA_THR) begin
        s_d.kvaThr = cfg.wrData[KVA_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q.sel <= SEL_RST;
      s_q.pol <= POL_RST;
      s_q.nodeExp <= NODE_EXP_RST;
      s_q.kvaThr <= KVA_THR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg.sel = s_q.sel;
  assign cfg.pol = s_q.pol;
  assign cfg.nodeExp = s_q.nodeExp;
  assign cfg.kvaThr = s_q.kvaThr;
endmodule : romx_cfg_store
`default_nettype wire

// [core/romx_top.sv]
// Relay output function multiplexer: twelve relay drivers, APB registers.
// Assumes all status inputs are synchronous to core_clk.
//
// Operation
// - Outputs 1,2,5,7,9 carry fixed breaker, fuel, starter, horn functions.
// - Outputs 3,4,6,8,10,11,12 each hold a selector; defaults 1,2,3,4,19,20,21.
// - Several outputs may share one function; all driven alike, no error.
// - Configuration always readable; written only while I/O lock is set.
// - Selection 21 latches on hard shutdown until cleared from the log.
// - Selection 20 latches on soft or hard shutdown until cleared.
// - Selection 19 latches on visual or higher alarm until cleared.
// - Selection 12 pulses 100 ms per 100 kWh of generated energy.
// - Selection 5 runs 5 s after emergency stop or overspeed, no latch.
// - Selection 23 stays on whenever the controller operates.
// - Selection 22 shows network node number differs from expected.
// - Selection 16 shows apparent power above the threshold.
// - Selection 15 shows generator alone supplying the load.
// - Selections 13 and 14 show analog 3 and 4 alarms.
// - Selections 17 and 18 show analog 3 and 4 pre-alarms.
// - Selection 6 enables external ignition when ignition is needed.
// - Selection 4 drives the governor idle/rated command.
// - Selection 2 drives the bus breaker shunt trip.
// - Each configurable output has a polarity bit, reset to normally open.
`timescale 1ns/1ps
`default_nettype none
module romx_top
  import romx_pkg::*;
#(
  parameter int TMR_W = 32,
  parameter logic [TMR_W-1:0] AIR_CYC = TMR_W'(AIR_SHUTOFF_CYC),
  parameter logic [TMR_W-1:0] PULSE_CYC = TMR_W'(ENERGY_PULSE_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fixed function commands
  input wire logic genBreakerClose,
  input wire logic genBreakerOpen,
  input wire logic fuelSolenoid,
  input wire logic starterCmd,
  input wire logic hornCmd,
  // Selectable function sources
  input wire logic busTripCmd,
  input wire logic preglowCmd,
  input wire logic idleRatedCmd,
  input wire logic emergencyStop,
  input wire logic overspeedEvent,
  input wire logic ignitionCmd,
  input wire logic speedRaise,
  input wire logic speedLower,
  input wire logic voltRaise,
  input wire logic voltLower,
  input wire logic engineRunning,
  input wire logic energy_increment_pulse,
  input wire logic analog3_alarm_flag,
  input wire logic analog4AlarmFlag,
  input wire logic generator_only_supplying,
  input wire logic [KVA_W-1:0] apparentPowerKva,
  input wire logic analog3PreAlarm,
  input wire logic analog4PreAlarm,
  input wire logic visualAlarmEvent,
  input wire logic softShutdownEvent,
  input wire logic hardShutdownEvent,
  input wire logic alarmLogClear,
  input wire logic [NODE_W-1:0] nodeNumSeen,
  input wire logic nodeNumValid,
  input wire logic ctrlOperating,
  // Relay drivers
  output logic [NUM_RELAY-1:0] relayOut
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    romx_bus_state_t bus;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic ioLock;
    // Alarm latches
    logic hardLatch;
    logic softLatch;
    logic visualLatch;
    // Triggers and relay image
    logic airTrig;
    logic energyTrig;
    logic [NUM_RELAY-1:0] relay;
  } romx_state_t;

  romx_state_t s_q, s_d;

  romx_cfg_if cfgBus ();

  logic airActive;
  logic pulseActive;
  logic [31:0] fnActive;
  logic [NUM_RELAY-1:0] relayNext;
  logic [31:0] readVal;
  logic readHit;
  logic accessCyc;
  logic setupCyc;

  ////////////////////////////////////////////////////////////////////////////
  // Function select decode, shared by every configurable output

  function automatic logic fn_pick(input logic [SEL_W-1:0] sel, input logic [31:0] fns);
    fn_pick = fns[sel];
  endfunction : fn_pick

  function automatic logic [11:0] sel_addr(input int idx);
    sel_addr = OFS_SEL0 + 12'(4 * idx);
  endfunction : sel_addr

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks

  // Selectors, polarity, node number, threshold
  romx_cfg_store u_store (
    .clk (core_clk),
    .rst (sys_rst),
    .cfg (cfgBus.store)
  );

  // Retriggerable hold timers
  romx_pulse_timer #(
    .CNT_W (TMR_W),
    .LEN (AIR_CYC)
  ) u_air_tmr (
    .clk (core_clk),
    .rst (sys_rst),
    .trig (s_q.airTrig),
    .active (airActive)
  );

  romx_pulse_timer #(
    .CNT_W (TMR_W),
    .LEN (PULSE_CYC)
  ) u_energy_tmr (
    .clk (core_clk),
    .rst (sys_rst),
    .trig (s_q.energyTrig),
    .active (pulseActive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end wiring

  // Write lands one edge before pready is sampled
  assign setupCyc = psel && !penable;
  assign accessCyc = psel && penable && (s_q.bus == BUS_WAIT);
  assign cfgBus.wrEn = accessCyc && pwrite;
  assign cfgBus.wrAddr = paddr;
  assign cfgBus.wrData = pwdata;
  assign cfgBus.ioLock = s_q.ioLock;

  ////////////////////////////////////////////////////////////////////////////
  // Function sources, indexed by selection value

  always_comb begin
    fnActive = '0;
    fnActive[FN_NONE] = 1'b0;
    fnActive[FN_BUS_TRIP] = busTripCmd;
    fnActive[FN_PREGLOW] = preglowCmd;
    fnActive[FN_IDLE_RATED] = idleRatedCmd;
    fnActive[FN_AIR_SHUTOFF] = airActive;
    fnActive[FN_IGNITION] = ignitionCmd;
    fnActive[FN_SPEED_RAISE] = speedRaise;
    fnActive[FN_SPEED_LOWER] = speedLower;
    fnActive[FN_VOLT_RAISE] = voltRaise;
    fnActive[FN_VOLT_LOWER] = voltLower;
    fnActive[FN_ENGINE_RUN] = engineRunning;
    fnActive[FN_ENERGY_PULSE] = pulseActive;
    fnActive[FN_AI3_ALARM] = analog3_alarm_flag;
    fnActive[FN_AI4_ALARM] = analog4AlarmFlag;
    fnActive[FN_GEN_ONLY] = generator_only_supplying;
    fnActive[FN_APPARENT_POWER_THRESHOLD_FLAG] = apparentPowerKva > cfgBus.kvaThr;
    fnActive[FN_AI3_PRE] = analog3PreAlarm;
    fnActive[FN_AI4_PRE] = analog4PreAlarm;
    // Alarm latches
    fnActive[FN_VISUAL] = s_q.visualLatch;
    fnActive[FN_SOFT_SD] = s_q.softLatch;
    fnActive[FN_HARD_SD] = s_q.hardLatch;
    // Network and supervision
    fnActive[FN_NODE_MISMATCH] = nodeNumValid && (nodeNumSeen != cfgBus.nodeExp);
    fnActive[FN_SELF_TEST] = ctrlOperating;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Relay map

  always_comb begin
    relayNext = '0;
    // Fixed outputs ignore selectors
    relayNext[RLY_GEN_CLOSE] = genBreakerClose;
    relayNext[RLY_GEN_OPEN] = genBreakerOpen;
    relayNext[RLY_FUEL] = fuelSolenoid;
    relayNext[RLY_STARTER] = starterCmd;
    relayNext[RLY_HORN] = hornCmd;

    for (int i = 0; i < NUM_CFG; i++) begin
      // Independent decode per output, so shared selections need no arbitration
      relayNext[CFG_RELAY_POS[i]] = fn_pick(cfgBus.sel[i], fnActive) ^ cfgBus.pol[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux

  always_comb begin
    // No read side effects
    readVal = '0;
    readHit = 1'b1;
    case (paddr)
      OFS_CTRL: readVal[CTRL_LOCK_BIT] = s_q.ioLock;
      OFS_POL: readVal[NUM_CFG-1:0] = cfgBus.pol;
      OFS_NODE_EXP: readVal[NODE_W-1:0] = cfgBus.nodeExp;
      OFS_KVA_THR: readVal[KVA_W-1:0] = cfgBus.kvaThr;
      OFS_STATUS: begin
        readVal[NUM_RELAY-1:0] = s_q.relay;
        readVal[STAT_LATCH_LSB +: 3] = {s_q.hardLatch, s_q.softLatch, s_q.visualLatch};
      end
      default: begin
        // SEL words
        readHit = 1'b0;
        for (int i = 0; i < NUM_CFG; i++) begin
          if (paddr == sel_addr(i)) begin
            readVal[SEL_W-1:0] = cfgBus.sel[i];
            readHit = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b0;
    s_d.err = 1'b0;

    // One wait state, one-cycle ready
    case (s_q.bus)
      BUS_IDLE: begin
        if (setupCyc) begin
          s_d.bus = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        if (accessCyc) begin
          s_d.bus = BUS_DONE;
          s_d.ready = 1'b1;
          s_d.rdata = pwrite ? '0 : readVal;
          if (pwrite) begin
            // CTRL always writable
            if (paddr == OFS_CTRL) begin
              s_d.ioLock = pwdata[CTRL_LOCK_BIT];
            end else begin
              s_d.err = !cfgBus.wrOk;
            end
          end else begin
            s_d.err = !readHit;
          end
        end else if (!psel) begin
          s_d.bus = BUS_IDLE;
        end
      end
      BUS_DONE: begin
        s_d.bus = setupCyc ? BUS_WAIT : BUS_IDLE;
      end
      default: s_d.bus = BUS_IDLE;
    endcase

    // Set wins over a clear arriving in the same cycle
    if (alarmLogClear) begin
      s_d.hardLatch = 1'b0;
      s_d.softLatch = 1'b0;
      s_d.visualLatch = 1'b0;
    end
    if (hardShutdownEvent) begin
      s_d.hardLatch = 1'b1;
    end

    if (hardShutdownEvent || softShutdownEvent) begin
      s_d.softLatch = 1'b1;
    end

    if (visualAlarmEvent || softShutdownEvent || hardShutdownEvent) begin
      s_d.visualLatch = 1'b1;
    end

    // Registered triggers
    s_d.airTrig = emergencyStop || overspeedEvent;
    s_d.energyTrig = energy_increment_pulse;

    // Polarity already applied
    s_d.relay = relayNext;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q.bus <= BUS_IDLE;
      s_q.rdata <= '0;
      s_q.ready <= 1'b0;
      s_q.err <= 1'b0;
      s_q.ioLock <= 1'b0;
      s_q.hardLatch <= 1'b0;
      s_q.softLatch <= 1'b0;
      s_q.visualLatch <= 1'b0;
      s_q.airTrig <= 1'b0;
      s_q.energyTrig <= 1'b0;
      s_q.relay <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign relayOut = s_q.relay;

endmodule : romx_top
`default_nettype wire

// [test/romx_monitor.sv]
// Port checker of the relay mux: fixed outputs, APB answers, shutdown latches.
// Assumes outputs 11 and 12 keep their reset selection and polarity.
`timescale 1ns/1ps
`default_nettype none
module romx_monitor
  import romx_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sources
  input wire logic genBreakerClose,
  input wire logic genBreakerOpen,
  input wire logic fuelSolenoid,
  input wire logic starterCmd,
  input wire logic hornCmd,
  input wire logic softShutdownEvent,
  input wire logic hardShutdownEvent,
  input wire logic alarmLogClear,
  // Relays
  input wire logic [NUM_RELAY-1:0] relayOut
);
  logic lockQ;
  logic hardQ;
  logic softQ;
  logic done;
  assign done = psel && penable && pready;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of lock and latches
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lockQ <= 1'b0;
      hardQ <= 1'b0;
      softQ <= 1'b0;
    end else begin
      if (done && pwrite && paddr == OFS_CTRL && !pslverr) begin
        lockQ <= pwdata[CTRL_LOCK_BIT];
      end
      hardQ <= hardShutdownEvent || (hardQ && !alarmLogClear);
      softQ <= softShutdownEvent || hardShutdownEvent || (softQ && !alarmLogClear);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_fixed_close: assert property (!$past(sys_rst) |->
    relayOut[RLY_GEN_CLOSE] == $past(genBreakerClose)) else $error("breaker close relay");
  a_fixed_rest: assert property (!$past(sys_rst) |->
    {relayOut[RLY_GEN_OPEN], relayOut[RLY_FUEL], relayOut[RLY_STARTER], relayOut[RLY_HORN]}
    == $past({genBreakerOpen, fuelSolenoid, starterCmd, hornCmd})) else $error("fixed relays");
  a_apb_answer: assert property (psel && $rose(penable) |=> pready)
    else $error("late answer");
  a_ready_single: assert property (pready |=> !pready) else $error("long ready");
  a_locked_refuse: assert property (done && pwrite && !lockQ && paddr != OFS_CTRL
    |-> pslverr) else $error("write accepted unlocked");
  a_cfg_readable: assert property (done && !pwrite && paddr >= OFS_SEL0
    && paddr <= OFS_SEL_LAST && paddr[1:0] == 2'h0 |-> !pslverr) else $error("read refused");
  a_sel_range: assert property (done && pwrite && paddr == OFS_SEL0
    && (pwdata == 32'h0 || pwdata == 32'h18) |-> pslverr) else $error("bad selection kept");
  a_hard_latch: assert property (!$past(sys_rst) |->
    relayOut[11] == $past(hardQ)) else $error("hard shutdown relay");
  a_soft_latch: assert property (!$past(sys_rst) |->
    relayOut[10] == $past(softQ)) else $error("soft shutdown relay");
  c_lock_on: cover property (done && pwrite && paddr == OFS_CTRL && pwdata[0]);
  c_refused: cover property (done && pslverr);
  c_hard: cover property ($rose(relayOut[11]));
endmodule : romx_monitor
`default_nettype wire

// [test/romx_relay_bank.sv]
// Relay coils with normally open contacts behind the relay drivers.
// Assumes coil 1 energizes; contacts settle within the cycle.
`timescale 1ns/1ps
`default_nettype none
module romx_relay_bank
  import romx_pkg::*;
(
  // Coils and contacts
  input wire logic [NUM_RELAY-1:0] coil,
  output logic [NUM_RELAY-1:0] contact
);
  assign contact = coil;
endmodule : romx_relay_bank
`default_nettype wire

// [test/relay_output_function_mux_tb_top.sv]
// Bench of the relay mux: defaults, lock, function table, timers, latches.
// Assumes short timer parameters; outputs 11 and 12 keep their defaults.
`timescale 1ns/1ps
`default_nettype none
module relay_output_function_mux_tb_top;
  import romx_pkg::*;
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic exp;
  } romx_row_t;
  localparam int AIRN = 50;
  localparam int PULN = 10;
  logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, ovs = 1'b0, clr = 1'b0, nodeValid = 1'b0;
  logic [4:0] fixV = 5'h00;
  logic [23:0] srcV = 24'h0;
  logic [KVA_W-1:0] kva = 16'h0000;
  logic [NODE_W-1:0] nodeSeen = 8'h00;
  logic [NUM_RELAY-1:0] relayOut, contact;
  int fail_count = 0, cmp_count = 0, c;
  romx_row_t rows [16] = '{'{5'h01, 1'b0}, '{5'h02, 1'b1}, '{5'h03, 1'b1}, '{5'h04, 1'b1},
    '{5'h06, 1'b1}, '{5'h07, 1'b1}, '{5'h08, 1'b1}, '{5'h09, 1'b1}, '{5'h0A, 1'b1},
    '{5'h0B, 1'b1}, '{5'h0D, 1'b1}, '{5'h0E, 1'b1}, '{5'h0F, 1'b1}, '{5'h11, 1'b1},
    '{5'h12, 1'b1}, '{5'h17, 1'b1}};
  logic [4:0] dflt [7] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h13, 5'h14, 5'h15};
  always #2.5 core_clk = ~core_clk;
  romx_top #(.AIR_CYC(32'(AIRN)), .PULSE_CYC(32'(PULN))) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .genBreakerClose(fixV[0]), .genBreakerOpen(fixV[1]), .fuelSolenoid(fixV[2]),
    .starterCmd(fixV[3]), .hornCmd(fixV[4]), .busTripCmd(srcV[2]), .preglowCmd(srcV[3]),
    .idleRatedCmd(srcV[4]), .emergencyStop(srcV[5]), .overspeedEvent(ovs),
    .ignitionCmd(srcV[6]), .speedRaise(srcV[7]), .speedLower(srcV[8]), .voltRaise(srcV[9]),
    .voltLower(srcV[10]), .engineRunning(srcV[11]), .energy_increment_pulse(srcV[12]),
    .analog3_alarm_flag(srcV[13]), .analog4AlarmFlag(srcV[14]),
    .generator_only_supplying(srcV[15]), .apparentPowerKva(kva), .analog3PreAlarm(srcV[17]),
    .analog4PreAlarm(srcV[18]), .visualAlarmEvent(srcV[19]), .softShutdownEvent(srcV[20]),
    .hardShutdownEvent(srcV[21]), .alarmLogClear(clr), .nodeNumSeen(nodeSeen),
    .nodeNumValid(nodeValid), .ctrlOperating(srcV[23]), .relayOut(relayOut));
  romx_relay_bank u_bank (.coil(relayOut), .contact(contact));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // Setup, access until pready, release, one idle edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic ee);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'(pready));
      summarize();
    end
    if (!w) begin
      chk("prdata", e, prdata);
    end
    chk("pslverr", 32'(ee), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask : apb
  task automatic fire(input int b);
    srcV <= 24'h1 << b;
    tick(1);
    srcV <= 24'h0;
  endtask : fire
  task automatic count(input logic v, output int n);
    n = 0;
    for (int i = 0; i < 200; i++) begin
      tick(1);
      if (contact[2] === v) n++;
    end
  endtask : count
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(2);
    sys_rst <= 1'b0;
    foreach (dflt[i]) apb(0, OFS_SEL0 + 12'(4 * i), 0, 32'(dflt[i]), 0);
    apb(0, OFS_POL, 0, 32'h0, 0);
    apb(1, OFS_SEL0, 32'hD, 0, 1);
    apb(0, OFS_SEL0, 0, 32'h1, 0);
    apb(1, OFS_CTRL, 32'h1, 0, 0);
    apb(1, OFS_SEL0, 32'h0, 0, 1);
    apb(1, OFS_SEL0, 32'h18, 0, 1);
    apb(0, 12'h0FC, 0, 32'h0, 1);
    apb(1, OFS_STATUS, 32'h0, 0, 1);
    for (int i = 0; i < 5; i++) begin
      fixV <= 5'h01 << i;
      tick(2);
      chk("fixed", 32'(fixV), 32'({contact[8], contact[6], contact[4], contact[1], contact[0]}));
    end
    fixV <= 5'h00;
    foreach (rows[i]) begin
      apb(1, OFS_SEL0, 32'(rows[i].sel), 0, 0);
      srcV <= 24'h1 << rows[i].sel;
      tick(2);
      chk("row on", 32'(rows[i].exp), 32'(contact[2]));
      srcV <= 24'h0;
      tick(2);
      chk("row off", 32'h0, 32'(contact[2]));
    end
    for (int i = 0; i < 3; i++) apb(1, OFS_SEL0 + 12'(4 * i), 32'hD, 0, 0);
    srcV <= 24'h1 << 13;
    tick(2);
    chk("shared", 32'h7, 32'({contact[5], contact[3], contact[2]}));
    srcV <= 24'h0;
    apb(1, OFS_SEL0, 32'h7, 0, 0);
    apb(1, OFS_SEL0 + 12'h004, 32'h8, 0, 0);
    srcV <= 24'h1 << 8;
    tick(2);
    chk("bias pair", 32'h2, 32'({contact[3], contact[2]}));
    srcV <= 24'h0;
    apb(1, OFS_SEL0, 32'h1, 0, 0);
    apb(1, OFS_POL, 32'h1, 0, 0);
    tick(1);
    chk("pol idle", 32'h1, 32'(contact[2]));
    apb(1, OFS_SEL0, 32'h5, 0, 0);
    ovs <= 1'b1;
    tick(1);
    ovs <= 1'b0;
    count(1'b0, c);
    chk("air inverted", 32'(AIRN), 32'(c));
    apb(1, OFS_POL, 32'h0, 0, 0);
    fire(5);
    count(1'b1, c);
    chk("air", 32'(AIRN), 32'(c));
    apb(1, OFS_SEL0, 32'hC, 0, 0);
    fire(12);
    count(1'b1, c);
    chk("energy", 32'(PULN), 32'(c));
    apb(1, OFS_KVA_THR, 32'd100, 0, 0);
    apb(1, OFS_SEL0, 32'h10, 0, 0);
    kva <= 16'd100;
    tick(2);
    chk("kva equal", 32'h0, 32'(contact[2]));
    kva <= 16'd101;
    tick(2);
    chk("kva above", 32'h1, 32'(contact[2]));
    apb(1, OFS_SEL0, 32'h16, 0, 0);
    nodeValid <= 1'b1;
    nodeSeen <= 8'h01;
    tick(2);
    chk("node match", 32'h0, 32'(contact[2]));
    nodeSeen <= 8'h02;
    tick(2);
    chk("node differ", 32'h1, 32'(contact[2]));
    for (int i = 0; i < 3; i++) begin
      fire(19 + i);
      tick(3);
      chk("latch", 32'((2 << i) - 1), 32'(contact[11:9]));
      c = (2 << i) - 1;
      apb(0, OFS_STATUS, 0, 32'((c << STAT_LATCH_LSB) | (c << 9) | 4), 0);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(3);
      chk("cleared", 32'h0, 32'(contact[11:9]));
    end
    fire(21);
    sys_rst <= 1'b1;
    tick(2);
    sys_rst <= 1'b0;
    tick(1);
    chk("reset relays", 32'h0, 32'(contact));
    srcV <= 24'h1C;
    tick(2);
    chk("defaults", 32'h7, 32'({contact[7], contact[5], contact[3]}));
    srcV <= 24'h0;
    apb(0, OFS_SEL0, 0, 32'h1, 0);
    apb(1, OFS_SEL0, 32'hD, 0, 1);
    summarize();
  end
endmodule : relay_output_function_mux_tb_top
bind romx_top romx_monitor u_mon (
  .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .genBreakerClose(genBreakerClose), .genBreakerOpen(genBreakerOpen),
  .fuelSolenoid(fuelSolenoid), .starterCmd(starterCmd), .hornCmd(hornCmd),
  .softShutdownEvent(softShutdownEvent), .hardShutdownEvent(hardShutdownEvent),
  .alarmLogClear(alarmLogClear), .relayOut(relayOut)
);
`default_nettype wire
